// ==== hdl/ckg_clock_ctrl.sv ====
// clock generator control: oscillator start-up, frequency measure, pll lock
// Functional notes
// (R1) after reset main oscillator is off and slow clock is the system source
// (R2) clearing oscillator enable clears the stable flag at once
// (R3) enabling oscillator clears stable and loads down-counter, ticking at slow/8
// (R4) start-up count field is eight bits wide
// (R5) counter at zero sets stable flag and may raise masked interrupt
// (R6) once stable, measure counts main clock after next slow rising edge
// (R7) at sixteenth slow falling edge set done and stop the counter
// (R8) readable count holds main cycles over sixteen slow periods
// (R9) software sets bypass and clears enable when an external clock is used
// (R10) each pll input divider accepts 1 through 255
// (R11) divider zero holds divider and pll output low
// (R12) reset clears every divider field to zero
// (R13) pll output is source times multiplier plus one over divider
// (R14) multiplier zero powers the pll down, nonzero powers it up
// (R15) re-enable or parameter change clears lock and reloads lock counter
// (R16) lock counter drops each slow cycle, at zero sets lock and event
// (R17) software programs a lock count covering the pll transient
// (R18) second pll is meant for 12 MHz in and 96 MHz out
// (R19) losing stable clears done and the measurement counter
//
// The address map and strobed register access were chosen for this implementation.
`default_nettype none
module ckg_clock_ctrl (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slowClk,
	input wire logic mainClkTick,
	input wire logic [ckg_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ckg_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [ckg_pkg::DATA_W-1:0] regRdata,
	output logic irq,
	output logic mainOscEnable,
	output logic osc_bypass_a,
	output logic sysClkSlow,
	output ckg_pkg::ckg_pll_s pllCfgA,
	output ckg_pkg::ckg_pll_s pllCfgB,
	output logic [ckg_pkg::NUM_PLL-1:0] pllPowerOn,
	output logic [ckg_pkg::NUM_PLL-1:0] pllClkOn
);
	typedef struct packed {
		logic oscEn;
		logic bypass;
		logic [ckg_pkg::OSC_CNT_W-1:0] oscLoad;
		logic [ckg_pkg::OSC_CNT_W-1:0] oscCnt;
		logic oscRun;
		logic stable;
		logic [2:0] div8;
		logic slowPrev;
		ckg_pkg::ckg_meas_e meas;
		logic [4:0] fallCnt;
		logic [ckg_pkg::FREQ_W-1:0] freq;
		logic done;
		ckg_pkg::ckg_pll_s [ckg_pkg::NUM_PLL-1:0] pll;
		logic [ckg_pkg::NUM_PLL-1:0][ckg_pkg::PLL_CNT_W-1:0] lockCnt;
		logic [ckg_pkg::NUM_PLL-1:0] lockRun;
		logic [ckg_pkg::NUM_PLL-1:0] locked;
		logic [ckg_pkg::NUM_PLL-1:0] powerOn;
		logic [ckg_pkg::NUM_PLL-1:0] clkOn;
		logic [ckg_pkg::IRQ_W-1:0] isr;
		logic [ckg_pkg::IRQ_W-1:0] imr;
		logic irq;
		logic [ckg_pkg::DATA_W-1:0] rdata;
	} ckg_state_s;

	ckg_state_s s_q;
	ckg_state_s s_d;

	// unpack a pll configuration word
	function automatic ckg_pkg::ckg_pll_s pllFromWord(input logic [ckg_pkg::DATA_W-1:0] w);
		ckg_pkg::ckg_pll_s p;
		p.div = w[ckg_pkg::PLL_DIV_LO +: ckg_pkg::PLL_DIV_W];
		p.lockCnt = w[ckg_pkg::PLL_CNT_LO +: ckg_pkg::PLL_CNT_W];
		p.mult = w[ckg_pkg::PLL_MULT_LO +: ckg_pkg::PLL_MULT_W];
		return p;
	endfunction

	// pack a pll configuration back into a read word
	function automatic logic [ckg_pkg::DATA_W-1:0] pllToWord(input ckg_pkg::ckg_pll_s p);
		logic [ckg_pkg::DATA_W-1:0] w;
		w = '0;
		w[ckg_pkg::PLL_DIV_LO +: ckg_pkg::PLL_DIV_W] = p.div;
		w[ckg_pkg::PLL_CNT_LO +: ckg_pkg::PLL_CNT_W] = p.lockCnt;
		w[ckg_pkg::PLL_MULT_LO +: ckg_pkg::PLL_MULT_W] = p.mult;
		return w;
	endfunction

	logic slowRise;
	logic slowFall;
	logic div8Tick;
	logic wrMor;
	logic newEn;
	logic [ckg_pkg::IRQ_W-1:0] events;
	logic [ckg_pkg::NUM_PLL-1:0] wrPll;
	ckg_pkg::ckg_pll_s newPll;

	// slow clock edges; the pin is taken as synchronous to ref_clk
	assign slowRise = slowClk & ~s_q.slowPrev;
	assign slowFall = ~slowClk & s_q.slowPrev;
	assign div8Tick = slowRise && (s_q.div8 == ckg_pkg::DIV8_LAST);
	assign wrMor = regWrite && (regAddr == ckg_pkg::OFF_MOR);
	assign newEn = regWdata[ckg_pkg::MOR_EN];
	assign wrPll[0] = regWrite && (regAddr == ckg_pkg::OFF_PLLA);
	assign wrPll[1] = regWrite && (regAddr == ckg_pkg::OFF_PLLB);
	assign newPll = pllFromWord(regWdata);

	// next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		events = '0;
		s_d.slowPrev = slowClk;
		if (slowRise) begin
			s_d.div8 = s_q.div8 + 3'h1;
		end

		// main oscillator enable and start-up counter
		if (wrMor) begin
			s_d.oscEn = newEn;
			s_d.bypass = regWdata[ckg_pkg::MOR_BYP];
			s_d.oscLoad = regWdata[ckg_pkg::MOR_CNT_LO +: ckg_pkg::OSC_CNT_W]; // [R4]
			if (!newEn) begin
				s_d.stable = 1'b0; // [R2]
				s_d.oscRun = 1'b0;
			end else if (!s_q.oscEn) begin
				// restart from a whole slow/8 period so the delay is never short
				s_d.stable = 1'b0; // [R3]
				s_d.oscCnt = regWdata[ckg_pkg::MOR_CNT_LO +: ckg_pkg::OSC_CNT_W];
				s_d.oscRun = 1'b1;
				s_d.div8 = '0;
			end
		end else if (s_q.oscRun && div8Tick) begin
			if (s_q.oscCnt == '0) begin
				s_d.stable = 1'b1; // [R5]
				s_d.oscRun = 1'b0;
				events[ckg_pkg::SR_STABLE] = 1'b1;
			end else begin
				s_d.oscCnt = s_q.oscCnt - 1'b1; // [R3]
			end
		end

		// main clock frequency measurement
		if (!s_q.stable) begin
			s_d.meas = ckg_pkg::MEAS_IDLE; // [R19]
			s_d.freq = '0;
			s_d.done = 1'b0;
			s_d.fallCnt = '0;
		end else begin
			unique case (s_q.meas)
				ckg_pkg::MEAS_IDLE: begin
					s_d.meas = ckg_pkg::MEAS_ARM;
				end
				ckg_pkg::MEAS_ARM: begin
					if (slowRise) begin
						s_d.meas = ckg_pkg::MEAS_RUN; // [R6]
						s_d.fallCnt = '0;
					end
				end
				ckg_pkg::MEAS_RUN: begin
					if (mainClkTick) begin
						s_d.freq = s_q.freq + 1'b1; // [R8]
					end
					if (slowFall) begin
						s_d.fallCnt = s_q.fallCnt + 5'h01;
						if (s_q.fallCnt == ckg_pkg::MEAS_LAST_FALL) begin
							s_d.meas = ckg_pkg::MEAS_DONE; // [R7]
							s_d.done = 1'b1;
							events[ckg_pkg::SR_MRDY] = 1'b1;
						end
					end
				end
				ckg_pkg::MEAS_DONE: begin
					s_d.meas = ckg_pkg::MEAS_DONE; // count frozen for reading
				end
			endcase
		end

		// pll configuration and lock counters
		for (int i = 0; i < ckg_pkg::NUM_PLL; i++) begin
			if (wrPll[i]) begin
				s_d.pll[i] = newPll; // [R10] [R13]
				if (newPll != s_q.pll[i]) begin
					s_d.locked[i] = 1'b0; // [R15]
					s_d.lockCnt[i] = newPll.lockCnt;
					s_d.lockRun[i] = (newPll.mult != '0); // [R14]
				end
			end else if (s_q.lockRun[i] && slowRise) begin
				if (s_q.lockCnt[i] == '0) begin
					s_d.locked[i] = 1'b1; // [R16]
					s_d.lockRun[i] = 1'b0;
					events[ckg_pkg::SR_LOCK_A + i] = 1'b1;
				end else begin
					s_d.lockCnt[i] = s_q.lockCnt[i] - 1'b1; // [R16]
				end
			end
			s_d.powerOn[i] = (s_d.pll[i].mult != '0); // [R14]
			// a zero divider stops the clock even when the pll is powered
			s_d.clkOn[i] = s_d.powerOn[i] && (s_d.pll[i].div != '0); // [R11]
		end

		// mask register
		if (regWrite && (regAddr == ckg_pkg::OFF_IMR)) begin
			s_d.imr = regWdata[ckg_pkg::IRQ_W-1:0];
		end

		// read data, valid only in the cycle after the strobe
		s_d.rdata = '0;
		if (regRead) begin
			unique case (regAddr)
				ckg_pkg::OFF_MOR: begin
					s_d.rdata[ckg_pkg::MOR_EN] = s_q.oscEn;
					s_d.rdata[ckg_pkg::MOR_BYP] = s_q.bypass;
					s_d.rdata[ckg_pkg::MOR_CNT_LO +: ckg_pkg::OSC_CNT_W] = s_q.oscLoad;
				end
				ckg_pkg::OFF_MCFR: begin
					s_d.rdata[ckg_pkg::FREQ_W-1:0] = s_q.freq; // [R8]
					s_d.rdata[ckg_pkg::MCFR_RDY] = s_q.done;
				end
				ckg_pkg::OFF_PLLA: begin
					s_d.rdata = pllToWord(s_q.pll[0]);
				end
				ckg_pkg::OFF_PLLB: begin
					s_d.rdata = pllToWord(s_q.pll[1]);
				end
				ckg_pkg::OFF_SR: begin
					s_d.rdata[ckg_pkg::SR_STABLE] = s_q.stable;
					s_d.rdata[ckg_pkg::SR_LOCK_A] = s_q.locked[0];
					s_d.rdata[ckg_pkg::SR_LOCK_B] = s_q.locked[1];
					s_d.rdata[ckg_pkg::SR_MRDY] = s_q.done;
				end
				ckg_pkg::OFF_ISR: begin
					s_d.rdata[ckg_pkg::IRQ_W-1:0] = s_q.isr;
				end
				ckg_pkg::OFF_IMR: begin
					s_d.rdata[ckg_pkg::IRQ_W-1:0] = s_q.imr;
				end
				default: begin
					s_d.rdata = '0; // unmapped reads return zero
				end
			endcase
		end

		// sticky events; a new event wins over the clear-on-read
		if (regRead && (regAddr == ckg_pkg::OFF_ISR)) begin
			s_d.isr = events;
		end else begin
			s_d.isr = s_q.isr | events;
		end
		s_d.irq = |(s_d.isr & s_d.imr); // [R5] [R16]
	end

	// state register; every divider and multiplier field starts at zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0; // [R1] [R12]
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flip-flops
	assign regRdata = s_q.rdata;
	assign irq = s_q.irq;
	assign mainOscEnable = s_q.oscEn; // [R1]
	assign osc_bypass_a = s_q.bypass;
	// the slow clock stays the source while the main clock is not proven
	assign sysClkSlow = ~s_q.stable; // [R1]
	assign pllCfgA = s_q.pll[0];
	assign pllCfgB = s_q.pll[1];
	assign pllPowerOn = s_q.powerOn;
	assign pllClkOn = s_q.clkOn;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_reset_state: assert property ($fell(rst) |-> !mainOscEnable && sysClkSlow && pllCfgA.div == '0 // [R1]
		&& pllCfgB.div == '0) else $error("reset state wrong");
	a_osc_disable_clr: assert property (wrMor && !newEn |=> !sysClkSlow == 1'b0) // [R2]
		else $error("stable not cleared on disable");
	a_osc_enable_load: assert property (wrMor && newEn && !mainOscEnable // [R3]
		|=> sysClkSlow && s_q.oscCnt == $past(regWdata[ckg_pkg::MOR_CNT_LO +: ckg_pkg::OSC_CNT_W]))
		else $error("start-up load wrong");
	a_stable_irq_raise: assert property ($rose(s_q.stable) && s_q.imr[0] |-> irq) // [R5]
		else $error("stable interrupt missing");
	a_meas_frozen: assert property (s_q.done && s_q.stable |=> $stable(s_q.freq)) // [R7]
		else $error("count moved after done");
	a_meas_clear: assert property (!s_q.stable |=> !s_q.done && s_q.freq == '0) // [R19]
		else $error("measure not cleared");
	a_div_zero_low: assert property (pllCfgA.div == '0 |-> !pllClkOn[0]) // [R11]
		else $error("clock on with zero divider");
	a_mult_zero_off: assert property (wrPll[1] && newPll.mult == '0 |=> !pllPowerOn[1] && !s_q.locked[1]) // [R14]
		else $error("pll not powered down");
	a_lock_reload: assert property (wrPll[0] && newPll != pllCfgA // [R15]
		|=> !s_q.locked[0] && s_q.lockCnt[0] == pllCfgA.lockCnt) else $error("lock not reloaded");
	a_lock_set: assert property ($rose(s_q.locked[1]) |-> $past(s_q.lockCnt[1]) == '0 // [R16]
		&& $past(slowRise)) else $error("lock set early");

	// the remaining checks pin down counters, flags and register paths step by step, so a broken
	// divider or decrement cannot hide behind the coarse end-to-end checks

	// outputs leave reset quiet, with no pll powered
	a_reset_quiet: assert property ($fell(rst) |-> !irq && regRdata == '0 && pllPowerOn == '0) // [R1]
		else $error("outputs not quiet after reset");

	// a disable must also stop the start-up counter, not only drop the flag
	a_disable_no_run: assert property (wrMor && !newEn |=> !s_q.oscRun) // [R2]
		else $error("start-up counter still running");

	// a fresh enable restarts the slow/8 divider so the delay is never short
	a_enable_restart: assert property (wrMor && newEn && !mainOscEnable |=> s_q.div8 == '0 && s_q.oscRun) // [R3]
		else $error("start-up not restarted");

	// the start-up count drops by one on each slow/8 tick
	a_osc_tick_step: assert property (s_q.oscRun && div8Tick && !wrMor && s_q.oscCnt != '0 // [R3]
		|=> s_q.oscCnt == $past(s_q.oscCnt) - 1'b1) else $error("start-up step wrong");

	// stable only rises from a tick seen with the counter at zero
	a_stable_from_zero: assert property ($rose(s_q.stable) |-> $past(s_q.oscCnt) == '0 && $past(div8Tick)) // [R5]
		else $error("stable set early");

	// the stable event is latched into the sticky status
	a_event_sticky: assert property (events[ckg_pkg::SR_STABLE] |=> s_q.isr[ckg_pkg::SR_STABLE]) // [R5]
		else $error("stable event lost");

	// a status read with no event pending leaves the sticky bits empty
	a_isr_read_clear: assert property (regRead && regAddr == ckg_pkg::OFF_ISR && events == '0 // [R5]
		|=> s_q.isr == '0) else $error("event status not cleared");

	// the interrupt line is the registered or of masked status bits
	a_irq_level: assert property (irq == |(s_q.isr & s_q.imr)) // [R5] [R16]
		else $error("interrupt level wrong");

	// mask writes land whole in the mask register
	a_mask_write: assert property (regWrite && regAddr == ckg_pkg::OFF_IMR // [R5]
		|=> s_q.imr == $past(regWdata[ckg_pkg::IRQ_W-1:0])) else $error("mask not written");

	// read data stands only in the cycle after a read strobe
	a_rdata_idle: assert property (!regRead |=> regRdata == '0) // [R8]
		else $error("read data not idle");

	// counting starts only on a slow rising edge once stable
	a_meas_start_rise: assert property (s_q.stable && s_q.meas == ckg_pkg::MEAS_ARM && slowRise // [R6]
		|=> s_q.meas == ckg_pkg::MEAS_RUN) else $error("measure did not start");

	// each main clock tick adds one while the window is open
	a_meas_count_step: assert property (s_q.stable && s_q.meas == ckg_pkg::MEAS_RUN && mainClkTick // [R8]
		|=> s_q.freq == $past(s_q.freq) + 1'b1) else $error("measure step wrong");

	// done marks the sixteenth falling edge of the slow clock
	a_done_at_sixteen: assert property ($rose(s_q.done) |-> $past(s_q.fallCnt) == ckg_pkg::MEAS_LAST_FALL // [R7]
		&& $past(slowFall)) else $error("done at wrong edge");

	// a zero divider keeps pll b quiet too
	a_div_zero_low_b: assert property (pllCfgB.div == '0 |-> !pllClkOn[1]) // [R11]
		else $error("clock b on with zero divider");

	// no clock leaves pll a while it is powered down
	a_clk_needs_power: assert property (pllClkOn[0] |-> pllPowerOn[0]) // [R11] [R14]
		else $error("clock on while powered down");

	// a zero multiplier powers pll a down as well
	a_mult_zero_off_a: assert property (wrPll[0] && newPll.mult == '0 |=> !pllPowerOn[0]) // [R14]
		else $error("pll a not powered down");

	// an identical rewrite must not disturb the lock flag
	a_same_write_hold: assert property (wrPll[0] && newPll == pllCfgA |=> s_q.locked[0] == $past(s_q.locked[0])) // [R15]
		else $error("lock moved on identical write");

	// lock counters drop by one per slow clock period
	a_lock_step_a: assert property (s_q.lockRun[0] && slowRise && !wrPll[0] && s_q.lockCnt[0] != '0 // [R16]
		|=> s_q.lockCnt[0] == $past(s_q.lockCnt[0]) - 1'b1) else $error("lock a step wrong");
	a_lock_step_b: assert property (s_q.lockRun[1] && slowRise && !wrPll[1] && s_q.lockCnt[1] != '0 // [R16]
		|=> s_q.lockCnt[1] == $past(s_q.lockCnt[1]) - 1'b1) else $error("lock b step wrong");
endmodule
`default_nettype wire

// ==== hdl/ckg_pkg.sv ====
// constants, field layout and types of the clock generator control block
`default_nettype none
package ckg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFF_MOR = 8'h00;
	localparam logic [7:0] OFF_MCFR = 8'h04;
	localparam logic [7:0] OFF_PLLA = 8'h08;
	localparam logic [7:0] OFF_PLLB = 8'h0C;
	localparam logic [7:0] OFF_SR = 8'h10;
	localparam logic [7:0] OFF_ISR = 8'h14;
	localparam logic [7:0] OFF_IMR = 8'h18;
	// main oscillator config fields
	localparam int MOR_EN = 0;
	localparam int MOR_BYP = 1;
	localparam int MOR_CNT_LO = 8;
	localparam int OSC_CNT_W = 8;
	// pll config fields
	localparam int PLL_DIV_LO = 0;
	localparam int PLL_DIV_W = 8;
	localparam int PLL_CNT_LO = 8;
	localparam int PLL_CNT_W = 6;
	localparam int PLL_MULT_LO = 16;
	localparam int PLL_MULT_W = 11;
	localparam int NUM_PLL = 2;
	// frequency result fields
	localparam int FREQ_W = 16;
	localparam int MCFR_RDY = 16;
	// status and event bit positions
	localparam int SR_STABLE = 0;
	localparam int SR_LOCK_A = 1;
	localparam int SR_LOCK_B = 2;
	localparam int SR_MRDY = 3;
	localparam int IRQ_W = 4;
	// slow clock based timing
	localparam logic [2:0] DIV8_LAST = 3'h7;
	localparam logic [4:0] MEAS_LAST_FALL = 5'h0F;
	typedef struct packed {
		logic [PLL_MULT_W-1:0] mult;
		logic [PLL_CNT_W-1:0] lockCnt;
		logic [PLL_DIV_W-1:0] div;
	} ckg_pll_s;
	typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARM, MEAS_RUN, MEAS_DONE} ckg_meas_e;
endpackage
`default_nettype wire

// ==== test/clock_generator_osc_pll_control_tb.sv ====
// self-checking bench for the clock generator control block
`default_nettype none
module clock_generator_osc_pll_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic slowClk = 1'b0;
	logic mainClkTick = 1'b0;
	logic [ckg_pkg::ADDR_W-1:0] regAddr = 8'h00;
	logic [ckg_pkg::DATA_W-1:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [ckg_pkg::DATA_W-1:0] regRdata;
	logic irq;
	logic mainOscEnable;
	logic osc_bypass_a;
	logic sysClkSlow;
	ckg_pkg::ckg_pll_s pllCfgA;
	ckg_pkg::ckg_pll_s pllCfgB;
	logic [1:0] pllPowerOn;
	logic [1:0] pllClkOn;
	logic [3:0] slowDiv = 4'h0;
	logic [31:0] rdv;
	logic [7:0] a;
	int errTotal = 0;
	int samplesChecked = 0;
	int cyc = 0;
	int t0;

	always #4 ref_clk = ~ref_clk;

	// slow clock at one sixteenth of the reference, main ticks on every other cycle
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		slowDiv <= slowDiv + 4'h1;
		slowClk <= slowDiv[3];
		mainClkTick <= ~mainClkTick;
	end

	ckg_clock_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .slowClk(slowClk), .mainClkTick(mainClkTick),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .irq(irq), .mainOscEnable(mainOscEnable), .osc_bypass_a(osc_bypass_a),
		.sysClkSlow(sysClkSlow), .pllCfgA(pllCfgA), .pllCfgB(pllCfgB), .pllPowerOn(pllPowerOn),
		.pllClkOn(pllClkOn));

	task automatic conclude();
		$display("checked %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= ad;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= ad;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask

	// polls one register bit; running out of tries ends the run
	task automatic waitReg(input logic [7:0] ad, input int b, input logic v, input int bound);
		int n;
		n = 0;
		rd(ad, rdv);
		while (rdv[b] !== v && n < bound) begin
			rd(ad, rdv);
			n++;
		end
		if (n >= bound) begin
			errTotal++;
			$display("mismatch poll bit %0d expected %b seen %b", b, v, rdv[b]);
			conclude();
		end
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("sysClkSlow", 32'h1, {31'h0, sysClkSlow});
		chk("mainOscEnable", 32'h0, {31'h0, mainOscEnable});
		chk("div A", 32'h0, {24'h0, pllCfgA.div});
		chk("div B", 32'h0, {24'h0, pllCfgB.div});
		chk("pllClkOn", 32'h0, {30'h0, pllClkOn});
		rd(8'h1C, rdv);
		chk("unmapped", 32'h0, rdv);
		$display("test reset done");
		// start-up count 2 gives between two and three slow/8 periods
		wr(ckg_pkg::OFF_IMR, 32'h1);
		wr(ckg_pkg::OFF_MOR, 32'h0000_0201);
		t0 = cyc;
		rd(ckg_pkg::OFF_SR, rdv);
		chk("stable at enable", 32'h0, {31'h0, rdv[0]});
		chk("mainOscEnable", 32'h1, {31'h0, mainOscEnable});
		waitReg(ckg_pkg::OFF_SR, ckg_pkg::SR_STABLE, 1'b1, 400);
		chk("start-up time", 32'h1, {31'h0, (cyc - t0) >= 256 && (cyc - t0) <= 420});
		chk("sysClkSlow", 32'h0, {31'h0, sysClkSlow});
		chk("irq", 32'h1, {31'h0, irq});
		rd(ckg_pkg::OFF_ISR, rdv);
		chk("event stable", 32'h1, {31'h0, rdv[0]});
		@(posedge ref_clk);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test oscillator done");
		// sixteen slow periods hold 128 main ticks; edges of the window allow a few less
		waitReg(ckg_pkg::OFF_MCFR, ckg_pkg::MCFR_RDY, 1'b1, 300);
		chk("freq count", 32'h1, {31'h0, rdv[15:0] >= 16'd123 && rdv[15:0] <= 16'd129});
		repeat (64) @(posedge ref_clk);
		rd(ckg_pkg::OFF_MCFR, rdv);
		chk("freq frozen", 32'h1, {31'h0, rdv[16] && rdv[15:0] <= 16'd129});
		wr(ckg_pkg::OFF_MOR, 32'h0);
		rd(ckg_pkg::OFF_SR, rdv);
		chk("stable off", 32'h0, {31'h0, rdv[0]});
		chk("sysClkSlow", 32'h1, {31'h0, sysClkSlow});
		rd(ckg_pkg::OFF_MCFR, rdv);
		chk("freq cleared", 32'h0, rdv);
		wr(ckg_pkg::OFF_MOR, 32'h2);
		rd(ckg_pkg::OFF_SR, rdv);
		chk("bypass", 32'h2, {30'h0, osc_bypass_a, mainOscEnable});
		$display("test measure done");
		for (int i = 0; i < 2; i++) begin
			a = ckg_pkg::OFF_PLLA + 8'(4 * i);
			wr(a, 32'h0005_03FF);
			t0 = cyc;
			rd(ckg_pkg::OFF_SR, rdv);
			chk("lock at load", 32'h0, {31'h0, rdv[1 + i]});
			chk("pll cfg", {7'h0, 11'h005, 6'h03, 8'hFF}, {7'h0, (i == 0) ? pllCfgA : pllCfgB});
			chk("pll on", 32'h1, {31'h0, pllPowerOn[i] & pllClkOn[i]});
			waitReg(ckg_pkg::OFF_SR, ckg_pkg::SR_LOCK_A + i, 1'b1, 100);
			chk("lock time", 32'h1, {31'h0, (cyc - t0) >= 32 && (cyc - t0) <= 100});
			chk("masked irq", 32'h0, {31'h0, irq});
			rd(ckg_pkg::OFF_ISR, rdv);
			chk("lock event", 32'h1, {31'h0, rdv[1 + i]});
			wr(a, 32'h0007_03FF);
			rd(ckg_pkg::OFF_SR, rdv);
			chk("lock on change", 32'h0, {31'h0, rdv[1 + i]});
			wr(a, 32'h0000_03FF);
			rd(ckg_pkg::OFF_SR, rdv);
			chk("pll off", 32'h0, {31'h0, pllPowerOn[i]});
			repeat (100) @(posedge ref_clk);
			rd(ckg_pkg::OFF_SR, rdv);
			chk("no lock off", 32'h0, {31'h0, rdv[1 + i]});
			wr(a, 32'h0005_0300);
			rd(ckg_pkg::OFF_SR, rdv);
			chk("div zero", 32'h2, {30'h0, pllPowerOn[i], pllClkOn[i]});
			$display("test pll %0d done", i);
		end
		// pll b set for an eightfold product, as a 12 MHz input needs for 96 MHz
		wr(ckg_pkg::OFF_PLLB, 32'h0007_0801);
		rd(ckg_pkg::OFF_PLLB, rdv);
		chk("pll b usb", 32'h0007_0801, rdv);
		$display("test usb setting done");
		conclude();
	end
endmodule
`default_nettype wire
